// ===== rtl/timer_zero_pkg.sv
package timer_zero_pkg;

  // Register byte addresses on the APB side
  localparam logic [7:0] ADDR_RELOAD_LOW   = 8'h50;
  localparam logic [7:0] ADDR_RELOAD_HIGH  = 8'h54;
  localparam logic [7:0] ADDR_COUNT_LOW    = 8'h58;
  localparam logic [7:0] ADDR_COUNT_HIGH   = 8'h5C;
  localparam logic [7:0] ADDR_CONTROL      = 8'h60;
  localparam logic [7:0] ADDR_IRQ_FLAGS    = 8'h64;
  localparam logic [7:0] ADDR_IRQ_ENABLES  = 8'h68;

  // Reset values
  localparam logic [7:0] RST_RELOAD_LOW    = 8'h8D;
  localparam logic [7:0] RST_RELOAD_HIGH   = 8'h34;
  localparam logic [7:0] RST_CONTROL       = 8'h04;
  localparam logic [7:0] RST_COUNT_BYTE    = 8'h00;

  // Field positions
  localparam int         BIT_LOW_IRQ_EN    = 5;
  localparam int         BIT_RUN           = 2;
  localparam int         BIT_OVF_FLAG      = 2;
  localparam int         BIT_TIMER_IRQ_EN  = 2;
  localparam logic [7:0] CONTROL_MASK      = 8'h24;
  localparam logic [7:0] FLAGS_MASK        = 8'h04;
  localparam logic [7:0] ENABLES_MASK      = 8'h04;

  // Tick prescaler: system clock divided by 12
  localparam int         TICK_DIVIDE       = 12;
  localparam logic [3:0] TICK_LAST         = 4'(TICK_DIVIDE - 1);

endpackage

// ===== rtl/tick_divider.sv
`timescale 1ns/1ps
module tick_divider
  import timer_zero_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // Enable and tick
  input  wire logic run,
  output logic      tick
);

  typedef struct packed
  {
    logic [3:0] count;
    logic       tick;
  } div_state_t;

  div_state_t state;
  div_state_t next_state;

  // One-cycle pulse every twelfth clock while running; prescaler freezes when stopped
  always_comb
  begin
    next_state      = state;
    next_state.tick = 1'b0;
    if (run)
    begin
      if (state.count == TICK_LAST)
      begin
        next_state.count = 4'h0;
        next_state.tick  = 1'b1;
      end
      else
      begin
        next_state.count = state.count + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state <= '0;
    else
      state <= next_state;
  end

  assign tick = state.tick;

endmodule

// ===== rtl/count_engine.sv
`timescale 1ns/1ps
module count_engine
  import timer_zero_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Control
  input  wire logic        tick,
  input  wire logic [15:0] reloadValue,
  input  wire logic        writeLow,
  input  wire logic        writeHigh,
  input  wire logic [7:0]  writeData,
  // Count and events
  output logic      [15:0] count,
  output logic             fullOverflow,
  output logic             lowOverflow
);

  typedef struct packed
  {
    logic [15:0] count;
    logic        full;
    logic        low;
  } eng_state_t;

  eng_state_t state;
  eng_state_t next_state;

  // Count up on tick, reload on full wrap; software writes override the count
  always_comb
  begin
    next_state      = state;
    next_state.full = 1'b0;
    next_state.low  = 1'b0;
    if (tick)
    begin
      if (state.count == 16'hFFFF)
      begin
        next_state.count = reloadValue;
        next_state.full  = 1'b1;
        next_state.low   = 1'b1;
      end
      else
      begin
        next_state.count = state.count + 16'h0001;
        next_state.low   = (state.count[7:0] == 8'hFF);
      end
    end
    // Write wins over a same-cycle tick so software sees what it wrote
    if (writeLow)
      next_state.count[7:0] = writeData;
    if (writeHigh)
      next_state.count[15:8] = writeData;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state <= '0;
    else
      state <= next_state;
  end

  assign count        = state.count;
  assign fullOverflow = state.full;
  assign lowOverflow  = state.low;

endmodule

// ===== rtl/auto_reload_timer_zero.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module auto_reload_timer_zero
  import timer_zero_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // Timer events
  output logic             irqRequest,
  output logic             overflowPulse,
  output logic             timeoutOwned
);

  typedef struct packed
  {
    logic [7:0]  reloadLow;
    logic [7:0]  reloadHigh;
    logic [7:0]  control;
    logic [7:0]  flags;
    logic [7:0]  enables;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        irq;
    logic        ovfPulse;
  } top_state_t;

  // Reset image: reload pair at its defaults, timer running, all else clear
  localparam top_state_t RESET_STATE = '{
    reloadLow:  RST_RELOAD_LOW,
    reloadHigh: RST_RELOAD_HIGH,
    control:    RST_CONTROL,
    default:    '0
  };

  top_state_t state;
  top_state_t next_state;

  logic        tick;
  logic [15:0] count;
  logic        fullOverflow;
  logic        lowOverflow;
  logic        access;
  logic        wrLane0;
  logic        writeLow;
  logic        writeHigh;

  // Known register address check
  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr == ADDR_RELOAD_LOW) || (addr == ADDR_RELOAD_HIGH)
            || (addr == ADDR_COUNT_LOW) || (addr == ADDR_COUNT_HIGH)
            || (addr == ADDR_CONTROL) || (addr == ADDR_IRQ_FLAGS)
            || (addr == ADDR_IRQ_ENABLES);
  endfunction

  // Access phase first cycle; answer comes one cycle later via registered pready
  assign access    = psel && penable && !state.ready;
  assign wrLane0   = access && pwrite && pstrb[0];
  assign writeLow  = wrLane0 && (paddr == ADDR_COUNT_LOW);
  assign writeHigh = wrLane0 && (paddr == ADDR_COUNT_HIGH);

  // Prescaler stops with run control, so a stopped timer makes no ticks
  tick_divider u_div
  (
    .ref_clk (ref_clk),
    .srst    (srst),
    .run     (state.control[BIT_RUN]),
    .tick    (tick)
  );

  count_engine u_eng
  (
    .ref_clk      (ref_clk),
    .srst         (srst),
    .tick         (tick),
    .reloadValue  ({state.reloadHigh, state.reloadLow}),
    .writeLow     (writeLow),
    .writeHigh    (writeHigh),
    .writeData    (pwdata[7:0]),
    .count        (count),
    .fullOverflow (fullOverflow),
    .lowOverflow  (lowOverflow)
  );

  // Register file, flag and interrupt logic
  always_comb
  begin
    next_state          = state;
    next_state.ready    = access;
    next_state.slverr   = access && !isMapped(paddr);
    next_state.rdata    = 32'h0000_0000;
    next_state.ovfPulse = fullOverflow;
    if (wrLane0)
    begin
      case (paddr)
        ADDR_RELOAD_LOW:  next_state.reloadLow  = pwdata[7:0];
        ADDR_RELOAD_HIGH: next_state.reloadHigh = pwdata[7:0];
        ADDR_CONTROL:     next_state.control    = pwdata[7:0] & CONTROL_MASK;
        ADDR_IRQ_FLAGS:   next_state.flags      = pwdata[7:0] & FLAGS_MASK;
        ADDR_IRQ_ENABLES: next_state.enables    = pwdata[7:0] & ENABLES_MASK;
        default:          next_state.enables    = state.enables;
      endcase
    end
    if (access && !pwrite)
    begin
      case (paddr)
        ADDR_RELOAD_LOW:  next_state.rdata[7:0] = state.reloadLow;
        ADDR_RELOAD_HIGH: next_state.rdata[7:0] = state.reloadHigh;
        ADDR_COUNT_LOW:   next_state.rdata[7:0] = count[7:0];
        ADDR_COUNT_HIGH:  next_state.rdata[7:0] = count[15:8];
        ADDR_CONTROL:     next_state.rdata[7:0] = state.control;
        ADDR_IRQ_FLAGS:   next_state.rdata[7:0] = state.flags;
        ADDR_IRQ_ENABLES: next_state.rdata[7:0] = state.enables;
        default:          next_state.rdata      = 32'h0000_0000;
      endcase
    end
    // Hardware set wins over a software clear in the same cycle
    if (fullOverflow)
      next_state.flags[BIT_OVF_FLAG] = 1'b1;
    // Interrupt request is a one-cycle pulse per qualifying event
    next_state.irq = state.enables[BIT_TIMER_IRQ_EN]
                     && (fullOverflow
                     || (lowOverflow && state.control[BIT_LOW_IRQ_EN]));
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state <= RESET_STATE;
    else
      state <= next_state;
  end

  assign pready        = state.ready;
  assign prdata        = state.rdata;
  assign pslverr       = state.slverr;
  assign irqRequest    = state.irq;
  assign overflowPulse = state.ovfPulse;
  // Timeout ownership is outside this block; software must honor it
  assign timeoutOwned  = 1'b0;

endmodule

// ===== testbench/timer_zero_sva.sv
`timescale 1ns/1ps
module timer_zero_sva
  import timer_zero_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Events
  input wire logic        irqRequest,
  input wire logic        overflowPulse,
  input wire logic        timeoutOwned
);
  logic irqEn;
  logic lowEn;
  logic wrHit;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Enables are not visible at the pins, so shadow them
  assign wrHit = psel && penable && pready && pwrite && pstrb[0];
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      irqEn <= 1'b0;
      lowEn <= 1'b0;
    end
    else if (wrHit && paddr == ADDR_IRQ_ENABLES)
      irqEn <= pwdata[2];
    else if (wrHit && paddr == ADDR_CONTROL)
      lowEn <= pwdata[5];
  end
  a_ovf_spacing: assert property (overflowPulse |=> (!overflowPulse) [*8])
    else $error("overflow pulses too close");
  a_irq_timer: assert property (overflowPulse && irqEn |-> irqRequest)
    else $error("overflow without interrupt");
  a_irq_cause: assert property (irqRequest |-> irqEn)
    else $error("interrupt while disabled");
  a_irq_low: assert property (irqRequest && !overflowPulse |-> lowEn)
    else $error("low wrap interrupt without enable");
  a_irq_single: assert property (irqRequest |=> !irqRequest)
    else $error("interrupt longer than one cycle");
  a_ctrl_unused: assert property (pready && paddr == ADDR_CONTROL |->
    prdata[7:6] == 2'h0 && prdata[4:3] == 2'h0 && prdata[1:0] == 2'h0)
    else $error("unused control bits not zero");
  a_bad_addr: assert property (pready && paddr[7:4] == 4'h7 |-> pslverr)
    else $error("unmapped address accepted");
  a_reply_time: assert property (psel && penable && !pready |=> pready)
    else $error("late bus answer");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_no_owner: assert property (!timeoutOwned)
    else $error("timeout owner set");
endmodule

bind auto_reload_timer_zero timer_zero_sva u_timer_zero_sva (.ref_clk(ref_clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .irqRequest(irqRequest), .overflowPulse(overflowPulse), .timeoutOwned(timeoutOwned));

// ===== testbench/auto_reload_timer_zero_bench.sv
`timescale 1ns/1ps
module auto_reload_timer_zero_bench;
  import timer_zero_pkg::*;
  logic        ref_clk = 0;
  logic        srst = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, irqRequest, overflowPulse, timeoutOwned;
  logic [31:0] prdata;
  logic [31:0] rdVal;
  logic        errVal;
  int          n_mismatch = 0;
  int          checks = 0;

  auto_reload_timer_zero u_auto_reload_timer_zero (.ref_clk(ref_clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irqRequest(irqRequest), .overflowPulse(overflowPulse), .timeoutOwned(timeoutOwned));

  // 200 MHz clock
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; latency is whatever pready says
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdVal = prdata;
    errVal = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rdVal, {24'h0, e});
  endtask

  // Bounded wait for an event pin
  task automatic waitFor(input bit irq);
    int n;
    n = 0;
    while ((irq ? irqRequest : overflowPulse) !== 1'b1 && n < 4000)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(n < 4000, 1);
  endtask

  task automatic t_reset;
    rd(ADDR_RELOAD_LOW, 8'h8D);
    rd(ADDR_RELOAD_HIGH, 8'h34);
    rd(ADDR_COUNT_HIGH, 8'h00);
    rd(ADDR_CONTROL, 8'h04);
    rd(ADDR_IRQ_FLAGS, 8'h00);
    rd(ADDR_IRQ_ENABLES, 8'h00);
    chk(timeoutOwned, 0);
    apb(1'b0, 8'h70, 8'h00);
    chk(errVal, 1);
    // Lane 0 strobe low: the write must be ignored
    pstrb <= 4'hE;
    apb(1'b1, ADDR_RELOAD_LOW, 8'h00);
    pstrb <= 4'hF;
    rd(ADDR_RELOAD_LOW, 8'h8D);
  endtask

  task automatic t_ctrl;
    apb(1'b1, ADDR_CONTROL, 8'hFF);
    rd(ADDR_CONTROL, 8'h24);
    apb(1'b1, ADDR_CONTROL, 8'h00);
    apb(1'b1, ADDR_COUNT_LOW, 8'h55);
    apb(1'b1, ADDR_COUNT_HIGH, 8'hAB);
    repeat (40) @(posedge ref_clk);
    rd(ADDR_COUNT_LOW, 8'h55);
    rd(ADDR_COUNT_HIGH, 8'hAB);
  endtask

  task automatic t_reload;
    int n;
    apb(1'b1, ADDR_RELOAD_LOW, 8'hF8);
    apb(1'b1, ADDR_RELOAD_HIGH, 8'hFF);
    apb(1'b1, ADDR_COUNT_HIGH, 8'hFF);
    apb(1'b1, ADDR_COUNT_LOW, 8'hFE);
    apb(1'b1, ADDR_CONTROL, 8'h04);
    waitFor(0);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (overflowPulse !== 1'b1 && n < 500);
    chk(n, 8 * TICK_DIVIDE);
    // Next tick is ten clocks after the overflow pulse, so the reloaded low byte still stands
    rd(ADDR_COUNT_LOW, 8'hF8);
    rd(ADDR_COUNT_HIGH, 8'hFF);
    rd(ADDR_IRQ_FLAGS, 8'h04);
    apb(1'b1, ADDR_IRQ_FLAGS, 8'h00);
    rd(ADDR_IRQ_FLAGS, 8'h00);
  endtask

  task automatic t_irq;
    apb(1'b1, ADDR_CONTROL, 8'h00);
    apb(1'b1, ADDR_IRQ_ENABLES, 8'h04);
    apb(1'b1, ADDR_COUNT_HIGH, 8'h00);
    apb(1'b1, ADDR_CONTROL, 8'h24);
    waitFor(1);
    chk(overflowPulse, 0);
    apb(1'b1, ADDR_COUNT_HIGH, 8'hFF);
    waitFor(0);
    chk(irqRequest, 1);
    apb(1'b1, ADDR_IRQ_ENABLES, 8'h00);
    waitFor(0);
    chk(irqRequest, 0);
  endtask

  task automatic complete_run;
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset;
    t_ctrl;
    t_reload;
    t_irq;
    complete_run;
  end

  // Watchdog, far beyond the few thousand cycles needed
  initial
  begin
    #100000;
    n_mismatch++;
    complete_run;
  end
endmodule
